// ---- rtl/crcc_defs.vh ----
// crc engine control block: register map, field positions, reset values
// assumes inclusion by bare name from the crcc design files
`ifndef CRCC_DEFS_VH
`define CRCC_DEFS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define CRCC_ADDR_CTRL 8'h00
`define CRCC_ADDR_POLYNOMIAL_LENGTH 8'h04
`define CRCC_ADDR_POLY 8'h08
`define CRCC_ADDR_INWORD 8'h0c
`define CRCC_ADDR_RESULT 8'h10

// ----------------------------------------------------------------------
// crc_control_1 field positions
// ----------------------------------------------------------------------
`define CRCC_BIT_ENGINE_ON 15
`define CRCC_BIT_IDLE_HALT 13
`define CRCC_VALID_WORD_COUNT_HI 12
`define CRCC_VALID_WORD_COUNT_LO 8
`define CRCC_BIT_FULL 7
`define CRCC_BIT_EMPTY 6
`define CRCC_BIT_ISEL 5
`define CRCC_BIT_RUN 4
`define CRCC_BIT_LSB_FIRST 3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CRCC_CTRL_BIT_RESET 1'b0
`define CRCC_POLYNOMIAL_LENGTH_RESET 5'h0f
`define CRCC_POLY_RESET 16'h0000
`define CRCC_RESULT_RESET 16'h0000
`define CRCC_RDATA_RESET 32'h00000000

// ----------------------------------------------------------------------
// fifo depth limits and shift counts
// ----------------------------------------------------------------------
`define CRCC_DEPTH_SHORT 5'h08
`define CRCC_DEPTH_LONG 5'h10
`define CRCC_POLYNOMIAL_LENGTH_SHORT_MAX 5'h07
`define CRCC_POLYNOMIAL_LENGTH_MAX 5'h0f
`define CRCC_LAST_BIT 4'hf
`define CRCC_CRC_MSB_MAX 4'hf

`endif

// ---- rtl/crcc_fifo.v ----
// crc engine input word fifo, 16 words of 16 bits with a depth limit
// push is ignored while full and pop while empty; clear is synchronous
`timescale 1ns/1ns

module crcc_fifo (
  input wire core_clk_i,
  input wire resetn_i,
  input wire clear_i,
  input wire depth_short_i,
  input wire push_i,
  input wire [15:0] push_data_i,
  input wire pop_i,
  output wire [15:0] pop_data_o,
  output wire [4:0] count_o,
  output wire full_o,
  output wire empty_o
);

`include "crcc_defs.vh"

  reg [15:0] mem [0:15];
  reg [3:0] wr_ptr;
  reg [3:0] rd_ptr;
  reg [4:0] count;
  wire [4:0] limit;
  wire do_push;
  wire do_pop;

  // ----------------------------------------------------------------------
  // depth limit and flags
  // ----------------------------------------------------------------------
  assign limit = depth_short_i ? `CRCC_DEPTH_SHORT : `CRCC_DEPTH_LONG;
  // limit may shrink under a held count, so compare with >=
  assign full_o = (count >= limit);
  assign empty_o = (count == 5'h00);
  assign count_o = count;
  assign pop_data_o = mem[rd_ptr];
  assign do_push = push_i & ~full_o;
  assign do_pop = pop_i & ~empty_o;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data_i;
    end
  end

  // ----------------------------------------------------------------------
  // pointers and count
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
    end else if (clear_i) begin
      wr_ptr <= 4'h0;
      rd_ptr <= 4'h0;
      count <= 5'h00;
    end else begin
      if (do_push) begin
        wr_ptr <= wr_ptr + 4'h1;
      end
      if (do_pop) begin
        rd_ptr <= rd_ptr + 4'h1;
      end
      if (do_push && !do_pop) begin
        count <= count + 5'h01;
      end else if (do_pop && !do_push) begin
        count <= count - 5'h01;
      end
    end
  end

endmodule

// ---- rtl/crcc_control.v ----
// crc engine control and status, with input fifo, serial shifter and
// result register, reached over an avalon-mm slave with waitrequest
// assumes one 100 mhz clock, device_idle_i synchronous to it
//
// The register offsets and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ns

// Summary of operation
// - engine on lets the module accept and process
// - engine off clears fifo, shifter, result register
// - idle halt stops the shifter in idle
// - bits 12..8 show valid words in fifo
// - depth 8 if length above 7, else 16
// - bit 7 reads one while fifo full
// - bit 6 reads one while fifo empty
// - select one: event when fifo goes empty
// - select zero: event when shifting completes
// - run bit starts and stops the shifter
// - order bit one shifts lsb first
// - bits 14 and 2..0 read zero
module crcc_control (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0] avs_byteenable_i,
  output reg [31:0] avs_readdata_o,
  output reg avs_waitrequest_o,
  input wire device_idle_i,
  output reg crc_event_o,
  output reg shift_busy_o
);

`include "crcc_defs.vh"

  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg engine_on;
  reg idle_halt_select;
  reg irq_source_select;
  reg shifter_run;
  reg lsb_first_select;
  reg [4:0] polynomial_length;
  reg [15:0] polynomial;
  reg [15:0] result_word;
  reg shift_state;
  reg [15:0] shift_reg;
  reg [3:0] bit_cnt;
  reg prev_empty;

  reg [31:0] next_readdata;
  reg [15:0] next_result;
  reg [15:0] crc_mask;
  reg [3:0] crc_msb;
  reg feedback;
  reg data_bit;
  reg next_event;

  wire req;
  wire take;
  wire wr_take;
  wire wr_ctrl;
  wire wr_polynomial_length;
  wire wr_poly;
  wire wr_inword;
  wire wr_result;
  wire [15:0] wdata;
  wire [15:0] ctrl_read;
  wire run_en;
  wire step;
  wire last_bit;
  wire pop;
  wire push;
  wire [15:0] fifo_data;
  wire [4:0] valid_word_count;
  wire fifo_full_flag;
  wire fifo_empty_flag;
  wire depth_short;
  wire empty_event;
  wire done_event;

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  assign req = avs_read_i | avs_write_i;
  // the edge where the master sees waitrequest low completes the access
  assign take = req & ~avs_waitrequest_o;
  assign wr_take = take & avs_write_i;

  // byte lanes 0 and 1 carry the 16-bit registers
  function [15:0] merge_bytes;
    input [15:0] old_val;
    input [15:0] new_val;
    input [1:0] be;
    begin
      merge_bytes[15:8] = be[1] ? new_val[15:8] : old_val[15:8];
      merge_bytes[7:0] = be[0] ? new_val[7:0] : old_val[7:0];
    end
  endfunction

  assign wdata = avs_writedata_i[15:0];

  // ----------------------------------------------------------------------
  // write strobes, one per register
  // ----------------------------------------------------------------------
  assign wr_ctrl = wr_take & (avs_address_i == `CRCC_ADDR_CTRL);
  assign wr_polynomial_length = wr_take & (avs_address_i == `CRCC_ADDR_POLYNOMIAL_LENGTH);
  assign wr_poly = wr_take & (avs_address_i == `CRCC_ADDR_POLY);
  assign wr_inword = wr_take & (avs_address_i == `CRCC_ADDR_INWORD);
  assign wr_result = wr_take & (avs_address_i == `CRCC_ADDR_RESULT);

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= `CRCC_RDATA_RESET;
    end else if (req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
      // read data change only on a read answer
      if (avs_read_i) begin
        avs_readdata_o <= next_readdata;
      end
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  assign ctrl_read = {
    engine_on,                 // bit 15
    1'b0,                      // bit 14
    idle_halt_select,          // bit 13
    valid_word_count,          // bits 12..8
    fifo_full_flag,            // bit 7
    fifo_empty_flag,           // bit 6
    irq_source_select,         // bit 5
    shifter_run,               // bit 4
    lsb_first_select,          // bit 3
    3'b000                     // bits 2..0
  };

  always @* begin
    next_readdata = 32'h00000000;
    case (avs_address_i)
      `CRCC_ADDR_CTRL: begin
        next_readdata = {16'h0000, ctrl_read};
      end
      `CRCC_ADDR_POLYNOMIAL_LENGTH: begin
        next_readdata = {27'h0000000, polynomial_length};
      end
      `CRCC_ADDR_POLY: begin
        next_readdata = {16'h0000, polynomial};
      end
      `CRCC_ADDR_RESULT: begin
        next_readdata = {16'h0000, result_word};
      end
      default: begin
        next_readdata = 32'h00000000;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  // turning the engine off leaves these bits as they are
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      engine_on <= `CRCC_CTRL_BIT_RESET;
      idle_halt_select <= `CRCC_CTRL_BIT_RESET;
      irq_source_select <= `CRCC_CTRL_BIT_RESET;
      shifter_run <= `CRCC_CTRL_BIT_RESET;
      lsb_first_select <= `CRCC_CTRL_BIT_RESET;
    end else if (wr_ctrl) begin
      if (avs_byteenable_i[1]) begin
        engine_on <= wdata[`CRCC_BIT_ENGINE_ON];
        idle_halt_select <= wdata[`CRCC_BIT_IDLE_HALT];
      end
      if (avs_byteenable_i[0]) begin
        irq_source_select <= wdata[`CRCC_BIT_ISEL];
        shifter_run <= wdata[`CRCC_BIT_RUN];
        lsb_first_select <= wdata[`CRCC_BIT_LSB_FIRST];
      end
    end
  end

  // ----------------------------------------------------------------------
  // length and polynomial registers
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      polynomial_length <= `CRCC_POLYNOMIAL_LENGTH_RESET;
      polynomial <= `CRCC_POLY_RESET;
    end else begin
      if (wr_polynomial_length && avs_byteenable_i[0]) begin
        polynomial_length <= wdata[4:0];
      end
      if (wr_poly) begin
        polynomial <= merge_bytes(polynomial, wdata, avs_byteenable_i[1:0]);
      end
    end
  end

  assign depth_short = (polynomial_length > `CRCC_POLYNOMIAL_LENGTH_SHORT_MAX);

  // ----------------------------------------------------------------------
  // input fifo
  // ----------------------------------------------------------------------
  // input words are only taken while the engine is on
  assign push = wr_inword & engine_on;

  crcc_fifo u_fifo (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .clear_i(~engine_on),
    .depth_short_i(depth_short),
    .push_i(push),
    .push_data_i(merge_bytes(16'h0000, wdata, avs_byteenable_i[1:0])),
    .pop_i(pop),
    .pop_data_o(fifo_data),
    .count_o(valid_word_count),
    .full_o(fifo_full_flag),
    .empty_o(fifo_empty_flag)
  );

  // ----------------------------------------------------------------------
  // shifter control
  // ----------------------------------------------------------------------
  assign run_en = engine_on & ~(idle_halt_select & device_idle_i);
  assign step = run_en & shifter_run;
  assign last_bit = (bit_cnt == 4'h0);
  assign pop = step & ~fifo_empty_flag &
               ((shift_state == ST_IDLE) | last_bit);

  // ----------------------------------------------------------------------
  // crc arithmetic for one bit
  // ----------------------------------------------------------------------
  always @* begin
    crc_msb = (polynomial_length > `CRCC_POLYNOMIAL_LENGTH_MAX) ?
              `CRCC_CRC_MSB_MAX : polynomial_length[3:0];
    crc_mask = 16'hffff >> (4'hf - crc_msb);
    data_bit = lsb_first_select ? shift_reg[0] : shift_reg[15];
    feedback = data_bit ^ result_word[crc_msb];
    next_result = ((result_word << 1) ^ (feedback ? polynomial : 16'h0000))
                  & crc_mask;
  end

  // ----------------------------------------------------------------------
  // shifter state machine
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_state <= ST_IDLE;
      shift_reg <= 16'h0000;
      bit_cnt <= 4'h0;
    end else if (!engine_on) begin
      shift_state <= ST_IDLE;
      shift_reg <= 16'h0000;
      bit_cnt <= 4'h0;
    end else begin
      case (shift_state)
        ST_IDLE: begin
          if (pop) begin
            shift_reg <= fifo_data;
            bit_cnt <= `CRCC_LAST_BIT;
            shift_state <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (step) begin
            if (last_bit) begin
              // next word loads on the last step, no idle gap
              if (pop) begin
                shift_reg <= fifo_data;
                bit_cnt <= `CRCC_LAST_BIT;
              end else begin
                shift_state <= ST_IDLE;
              end
            end else begin
              bit_cnt <= bit_cnt - 4'h1;
              if (lsb_first_select) begin
                shift_reg <= shift_reg >> 1;
              end else begin
                shift_reg <= shift_reg << 1;
              end
            end
          end
        end
        default: begin
          shift_state <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // result register
  // ----------------------------------------------------------------------
  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      result_word <= `CRCC_RESULT_RESET;
    end else if (!engine_on) begin
      result_word <= `CRCC_RESULT_RESET;
    end else if (shift_state == ST_SHIFT && step) begin
      result_word <= next_result;
    end else if (wr_result) begin
      // seed value, taken only while the shifter is not stepping
      result_word <= merge_bytes(result_word, wdata, avs_byteenable_i[1:0]);
    end
  end

  // ----------------------------------------------------------------------
  // event output
  // ----------------------------------------------------------------------
  // empty rising while enabled means the last word was just taken
  assign empty_event = engine_on & fifo_empty_flag & ~prev_empty;
  assign done_event = engine_on & step & (shift_state == ST_SHIFT) &
                      last_bit & fifo_empty_flag;

  // the select bit picks which of the two events reaches the pin
  always @* begin
    next_event = done_event;
    if (irq_source_select) begin
      next_event = empty_event;
    end
  end

  always @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prev_empty <= 1'b1;
      crc_event_o <= 1'b0;
      shift_busy_o <= 1'b0;
    end else begin
      prev_empty <= fifo_empty_flag;
      crc_event_o <= next_event;
      shift_busy_o <= engine_on & (shift_state == ST_SHIFT) &
                      ~(step & last_bit & ~pop);
    end
  end

endmodule

// ---- sim/crcc_control_monitor.sv ----
// checker for crcc_control: bus handshake, status fields, event pulse
// assumes binding to crcc_control, one clock, active-low async reset
`timescale 1ns/1ns

module crcc_control_monitor (
  input wire core_clk_i,
  input wire resetn_i,
  input wire [7:0] avs_address_i,
  input wire avs_read_i,
  input wire avs_write_i,
  input wire [31:0] avs_readdata_o,
  input wire avs_waitrequest_o,
  input wire crc_event_o,
  input wire shift_busy_o
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!resetn_i);
  wire ctrl_ans = !avs_waitrequest_o && avs_read_i && avs_address_i == 8'h00;

  chk_wait_answer: assert property ((avs_read_i || avs_write_i) &&
    avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest not low after request");
  chk_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low longer than one cycle");
  chk_unused_zero: assert property (ctrl_ans |->
    avs_readdata_o[14] == 1'b0 && avs_readdata_o[2:0] == 3'h0)
    else $error("unused control bits not zero");
  chk_empty_count: assert property (ctrl_ans |->
    avs_readdata_o[6] == (avs_readdata_o[12:8] == 5'h00))
    else $error("empty flag disagrees with count");
  chk_full_count: assert property (ctrl_ans && avs_readdata_o[7] |->
    avs_readdata_o[12:8] == 5'h08 || avs_readdata_o[12:8] == 5'h10)
    else $error("full flag at wrong count");
  chk_full_top: assert property (ctrl_ans &&
    avs_readdata_o[12:8] == 5'h10 |-> avs_readdata_o[7])
    else $error("full flag low at sixteen words");
  chk_count_range: assert property (ctrl_ans |->
    avs_readdata_o[12:8] <= 5'h10)
    else $error("word count above depth");
  chk_event_pulse: assert property (crc_event_o |=> !crc_event_o)
    else $error("event longer than one cycle");
  chk_unmapped_zero: assert property (!avs_waitrequest_o && avs_read_i &&
    avs_address_i == 8'h14 |-> avs_readdata_o == 32'h00000000)
    else $error("unmapped read not zero");

  cover property (crc_event_o && shift_busy_o);
  cover property (ctrl_ans && avs_readdata_o[7]);
  cover property (avs_write_i && !avs_waitrequest_o);
endmodule

// ---- sim/crcc_control_test.sv ----
// testbench for crcc_control: register rows, fifo depth, shifter, idle
// assumes the design files and crcc_defs.vh on the include path
`timescale 1ns/1ns
`include "crcc_defs.vh"

module crcc_control_test;
  reg core_clk_i = 1'b0;
  reg resetn_i = 1'b0;
  reg [7:0] adr = 8'h00;
  reg rd = 1'b0;
  reg wr = 1'b0;
  reg [31:0] wdat = 32'h00000000;
  reg [3:0] be = 4'hf;
  reg idle = 1'b0;
  wire [31:0] rdat;
  wire wait_o;
  wire evt;
  wire busy;
  integer n_mismatch = 0;
  integer cmp_count = 0;
  integer cyc = 0;
  integer i;
  reg [15:0] got;
  reg [15:0] crc;
  reg hit;
  reg bsy;
  reg [31:0] rows [0:7];

  crcc_control dut (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(be), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .device_idle_i(idle),
    .crc_event_o(evt), .shift_busy_o(busy)
  );

  initial begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task conclude;
    begin
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  task cmp(input [95:0] name, input [15:0] exp, input [15:0] act);
    begin
      cmp_count = cmp_count + 1;
      if (exp !== act) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", name, exp, act);
      end
    end
  endtask

  task bus(input w, input [7:0] a, input [15:0] d);
    begin
      @(posedge core_clk_i);
      adr <= a;
      wdat <= {16'h0000, d};
      rd <= !w;
      wr <= w;
      @(posedge core_clk_i);
      while (wait_o !== 1'b0) @(posedge core_clk_i);
      got = rdat[15:0];
      rd <= 1'b0;
      wr <= 1'b0;
    end
  endtask

  task wt(input [7:0] a, input [15:0] d);
    bus(1'b1, a, d);
  endtask

  task rdchk(input [7:0] a, input [15:0] exp, input [95:0] name);
    begin
      bus(1'b0, a, 16'h0000);
      cmp(name, exp, got);
    end
  endtask

  // waits n cycles, notes first event and busy beside it
  task wait_evt(input integer n);
    begin
      hit = 1'b0;
      bsy = 1'b0;
      repeat (n) begin
        @(posedge core_clk_i);
        if (evt === 1'b1 && !hit) begin
          hit = 1'b1;
          bsy = (busy === 1'b1);
        end
      end
    end
  endtask

  function [15:0] crc_step(input [15:0] c, input [15:0] w, input lsb);
    integer k;
    reg b;
    reg [15:0] r;
    begin
      r = c;
      for (k = 0; k < 16; k = k + 1) begin
        b = lsb ? w[k] : w[15 - k];
        r = {r[14:0], 1'b0} ^ ((b ^ r[15]) ? 16'h1021 : 16'h0000);
      end
      crc_step = r;
    end
  endfunction

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      conclude;
    end
  end

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    rows[0] = {16'hffff, 16'ha078};
    rows[1] = {16'h0000, 16'h0040};
    rows[2] = {16'h8000, 16'h8040};
    rows[3] = {16'h2000, 16'h2040};
    rows[4] = {16'h0020, 16'h0060};
    rows[5] = {16'h0010, 16'h0050};
    rows[6] = {16'h0008, 16'h0048};
    rows[7] = {16'h4007, 16'h0040};
    repeat (4) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    rdchk(`CRCC_ADDR_CTRL, 16'h0040, "ctrl_rst");
    rdchk(`CRCC_ADDR_POLYNOMIAL_LENGTH, 16'h000f, "polynomial_length_rst");
    rdchk(`CRCC_ADDR_RESULT, 16'h0000, "res_rst");
    wt(8'h14, 16'hffff);
    rdchk(8'h14, 16'h0000, "unmapped");
    $display("test reset done");
    for (i = 0; i < 8; i = i + 1) begin
      wt(`CRCC_ADDR_CTRL, rows[i][31:16]);
      rdchk(`CRCC_ADDR_CTRL, rows[i][15:0], "ctrl_row");
    end
    // only byte lane 0 lands: enable and idle halt stay clear
    be <= 4'h1;
    wt(`CRCC_ADDR_CTRL, 16'hffff);
    be <= 4'hf;
    rdchk(`CRCC_ADDR_CTRL, 16'h0078, "ctrl_lane0");
    $display("test rows done");
    wt(`CRCC_ADDR_CTRL, 16'h0000);
    wt(`CRCC_ADDR_POLYNOMIAL_LENGTH, 16'h0008);
    wt(`CRCC_ADDR_CTRL, 16'h8000);
    repeat (9) wt(`CRCC_ADDR_INWORD, 16'h5a5a);
    rdchk(`CRCC_ADDR_CTRL, 16'h8880, "depth8");
    wt(`CRCC_ADDR_POLYNOMIAL_LENGTH, 16'h0007);
    rdchk(`CRCC_ADDR_CTRL, 16'h8800, "depth16_mid");
    repeat (9) wt(`CRCC_ADDR_INWORD, 16'ha5a5);
    rdchk(`CRCC_ADDR_CTRL, 16'h9080, "depth16");
    rdchk(`CRCC_ADDR_INWORD, 16'h0000, "inword_rd");
    wt(`CRCC_ADDR_RESULT, 16'h1234);
    rdchk(`CRCC_ADDR_RESULT, 16'h1234, "seed");
    wt(`CRCC_ADDR_CTRL, 16'h0008);
    wt(`CRCC_ADDR_INWORD, 16'h1111);
    rdchk(`CRCC_ADDR_CTRL, 16'h0048, "off_clear");
    rdchk(`CRCC_ADDR_RESULT, 16'h0000, "res_clear");
    rdchk(`CRCC_ADDR_POLYNOMIAL_LENGTH, 16'h0007, "polynomial_length_kept");
    $display("test fifo done");
    wt(`CRCC_ADDR_POLYNOMIAL_LENGTH, 16'h000f);
    wt(`CRCC_ADDR_POLY, 16'h1021);
    wt(`CRCC_ADDR_CTRL, 16'h8000);
    wt(`CRCC_ADDR_INWORD, 16'hc3c3);
    wait_evt(40);
    rdchk(`CRCC_ADDR_CTRL, 16'h8100, "run_off");
    wt(`CRCC_ADDR_CTRL, 16'h8010);
    wait_evt(40);
    cmp("evt_done", 16'h0001, {15'h0000, hit});
    crc = crc_step(16'h0000, 16'hc3c3, 1'b0);
    rdchk(`CRCC_ADDR_RESULT, crc, "crc_msb");
    wt(`CRCC_ADDR_CTRL, 16'h8038);
    wt(`CRCC_ADDR_INWORD, 16'h0f01);
    wait_evt(40);
    cmp("evt_early", 16'h0001, {15'h0000, hit & bsy});
    crc = crc_step(crc, 16'h0f01, 1'b1);
    rdchk(`CRCC_ADDR_RESULT, crc, "crc_lsb");
    $display("test shift done");
    wt(`CRCC_ADDR_CTRL, 16'ha010);
    idle <= 1'b1;
    wt(`CRCC_ADDR_INWORD, 16'h7777);
    wait_evt(40);
    cmp("idle_stop", 16'h0000, {15'h0000, hit});
    rdchk(`CRCC_ADDR_CTRL, 16'ha110, "idle_hold");
    idle <= 1'b0;
    wait_evt(40);
    cmp("idle_resume", 16'h0001, {15'h0000, hit});
    wt(`CRCC_ADDR_CTRL, 16'h8010);
    idle <= 1'b1;
    wt(`CRCC_ADDR_INWORD, 16'h3333);
    wait_evt(40);
    cmp("idle_run", 16'h0001, {15'h0000, hit});
    $display("test idle done");
    conclude;
  end
endmodule

bind crcc_control crcc_control_monitor mon (
  .core_clk_i(core_clk_i), .resetn_i(resetn_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
  .avs_waitrequest_o(avs_waitrequest_o), .crc_event_o(crc_event_o),
  .shift_busy_o(shift_busy_o)
);
